// ==== logic/drd_pkg.sv ====
// Constants, types and register map of the digital reference decoder
package drd_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DISP = 12'h004;
  localparam logic [11:0] REG_REF  = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;

  // Control register: input_format_select in the low bits
  localparam int unsigned CTRL_FMT_LSB = 0;
  localparam int unsigned FMT_W        = 3;
  localparam logic [2:0]  FMT_RST      = 3'h0;

  // Display register: display_unit_select, 0 to 65535
  localparam int unsigned DISP_W   = 16;
  localparam logic [15:0] DISP_RST = 16'h0000;
  localparam logic [15:0] DISP_RPM = 16'h0002;
  localparam logic [15:0] DISP_USR = 16'h0028;

  // Input format codes
  localparam logic [2:0] FMT_BCD5 = 3'h6;
  localparam logic [2:0] FMT_BIN  = 3'h7;

  // Status register fields
  localparam int unsigned ST_VALID = 0;
  localparam int unsigned ST_FMT   = 1;
  localparam int unsigned ST_DIGIT = 2;
  localparam int unsigned ST_REV   = 3;
  localparam int unsigned ST_FULL  = 4;
  localparam int unsigned ST_UNIT  = 8;
  localparam int unsigned ST_MON   = 12;

  // Largest decimal digit
  localparam logic [3:0] BCD_MAX = 4'h9;

  // Unit of the accepted reference value
  typedef enum logic [3:0] {
    UNIT_PCT_1   = 4'h0,
    UNIT_PCT_01  = 4'h1,
    UNIT_PCT_001 = 4'h2,
    UNIT_HZ_1    = 4'h3,
    UNIT_HZ_01   = 4'h4,
    UNIT_HZ_001  = 4'h5,
    UNIT_BIN     = 4'h7,
    UNIT_RPM     = 4'h8,
    UNIT_USER    = 4'h9
  } drd_unit_type;

  // Unit of the reference monitor
  typedef enum logic [1:0] {
    MON_HZ   = 2'h0,
    MON_PCT  = 2'h1,
    MON_RPM  = 2'h2,
    MON_USER = 2'h3
  } drd_mon_type;

  // Reference lines as seen at the board
  typedef struct packed {
    logic [15:0] data;
    logic        sign;
    logic        strobe;
  } drd_pins_type;

  // Result of one decode
  typedef struct packed {
    logic [15:0] mag;
    logic        reverse;
    logic        full;
    logic        fmt_bad;
    logic        digit_bad;
  } drd_dec_type;

endpackage : drd_pkg

// ==== logic/drd_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module drd_sync #(
  parameter int unsigned W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] st1;
  logic [W-1:0] st2;
  logic [W-1:0] st3;
  logic [W-1:0] next_dout;

  // A bit moves only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      next_dout[i] = (st2[i] == st3[i]) ? st3[i] : dout[i];
    end
  end

  // Stage one feeds stage two and nothing else
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st1  <= '0;
      st2  <= '0;
      st3  <= '0;
      dout <= '0;
    end
    else
    begin
      st1  <= din;
      st2  <= st1;
      st3  <= st2;
      dout <= next_dout;
    end
  end
endmodule : drd_sync
`default_nettype wire

// ==== logic/drd_decode.sv ====
// Combinational decode of the reference lines for every input format
`timescale 1ns/1ps
`default_nettype none
module drd_decode (
  input  wire logic             [2:0] fmt,
  input  wire logic                   wide,
  input  wire logic                   narrow,
  input  wire drd_pkg::drd_pins_type  pins,
  output var drd_pkg::drd_dec_type    dec
);
  import drd_pkg::*;

  // Weighted decimal sum of up to five digits
  function automatic logic [15:0] bcd_sum(input logic [3:0] d1, input logic [3:0] d2,
                                          input logic [3:0] d3, input logic [3:0] d4,
                                          input logic [3:0] d5);
    int s;
    s = int'(d1) + 10 * int'(d2) + 100 * int'(d3) + 1000 * int'(d4) + 10000 * int'(d5);
    return s[15:0];
  endfunction : bcd_sum

  // True when a digit exceeds nine
  function automatic logic bad_digit(input logic [3:0] d);
    return d > BCD_MAX;
  endfunction : bad_digit

  logic [15:0] d;

  always_comb
  begin
    d             = pins.data;
    dec.mag       = '0;
    dec.reverse   = pins.sign;
    dec.full      = 1'b0;
    dec.fmt_bad   = 1'b0;
    dec.digit_bad = 1'b0;
    if (narrow)
    begin
      if (fmt == FMT_BIN)
      begin
        dec.mag  = {8'h00, d[7:0]};
        dec.full = &d[7:0];
      end
      else if (fmt == FMT_BCD5)
      begin
        dec.fmt_bad = 1'b1;
      end
      else
      begin
        // High digit may legally reach fifteen here
        dec.mag       = bcd_sum(d[3:0], d[7:4], 4'h0, 4'h0, 4'h0);
        dec.digit_bad = bad_digit(d[3:0]);
      end
    end
    else if (fmt == FMT_BIN)
    begin
      if (wide)
      begin
        dec.mag  = d;
        dec.full = &d;
      end
      else
      begin
        dec.mag  = {4'h0, d[11:0]};
        dec.full = &d[11:0];
      end
    end
    else if (fmt == FMT_BCD5)
    begin
      // Sign line is the top data bit, so the value is always forward
      dec.reverse = 1'b0;
      dec.fmt_bad = !wide;
      dec.mag     = bcd_sum({d[2:0], 1'b0}, d[6:3], d[10:7], d[14:11],
                            {2'b00, pins.sign, d[15]});
      dec.digit_bad = bad_digit(d[6:3]) | bad_digit(d[10:7]) | bad_digit(d[14:11]);
    end
    else if (wide)
    begin
      dec.mag       = bcd_sum(d[3:0], d[7:4], d[11:8], d[15:12], 4'h0);
      dec.digit_bad = bad_digit(d[3:0]) | bad_digit(d[7:4]) |
                      bad_digit(d[11:8]) | bad_digit(d[15:12]);
    end
    else
    begin
      dec.mag       = bcd_sum(d[3:0], d[7:4], d[11:8], 4'h0, 4'h0);
      dec.digit_bad = bad_digit(d[3:0]) | bad_digit(d[7:4]) | bad_digit(d[11:8]);
    end
  end
endmodule : drd_decode
`default_nettype wire

// ==== logic/drd_top.sv ====
// Digital reference decoder: pin capture, decode, hold and APB registers
`timescale 1ns/1ps
`default_nettype none
module drd_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Reference board lines
  input  wire logic [15:0] REF_DATA_IN,
  input  wire logic        REF_SIGN_IN,
  input  wire logic        REF_STROBE_IN,
  input  wire logic        WORD_WIDTH_16_IN,
  input  wire logic        BOARD_8BIT_IN,
  // Decoded reference
  output var  logic [15:0] REF_MAG,
  output var  logic        REF_REVERSE,
  output var  logic        REF_FULL_SCALE,
  output var  logic        REF_UPDATE,
  output var  logic [3:0]  REF_UNIT,
  output var  logic [1:0]  MON_UNIT,
  output var  logic        FORMAT_FAULT
);
  import drd_pkg::*;

  localparam int unsigned SYNC_W = 20;

  // Synchronised pins
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  drd_pins_type      pins;
  logic              wide;
  logic              narrow;

  // Software state
  logic [2:0]        input_format_select;
  logic [15:0]       display_unit_select;
  logic [2:0]        next_input_format_select;
  logic [15:0]       next_display_unit_select;

  // Decode path
  logic [2:0]        eff_fmt;
  drd_dec_type       dec;
  logic              accept;
  logic              ref_valid;
  logic              digit_fault;
  logic              next_ref_valid;
  logic              next_digit_fault;
  logic [15:0]       next_ref_mag;
  logic              next_ref_reverse;
  logic              next_ref_full;
  logic              next_ref_update;
  logic              next_format_fault;
  drd_unit_type      next_ref_unit;
  drd_mon_type       next_mon_unit;

  // APB
  logic              apb_done;
  logic              next_pready;
  logic [31:0]       next_prdata;
  logic              next_pslverr;

  // Every board pin passes the three-stage filter; sign and strobe are lines of their own
  assign pin_raw = {REF_DATA_IN, REF_SIGN_IN, REF_STROBE_IN,
                    WORD_WIDTH_16_IN, BOARD_8BIT_IN};

  drd_sync #(
    .W    (SYNC_W)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst_n(RST_N),
    .din  (pin_raw),
    .dout (pin_sync)
  );

  // Unpack the filtered lines
  assign pins   = pin_sync[SYNC_W-1:2];
  assign wide   = pin_sync[1];
  assign narrow = pin_sync[0];

  // A display setting of 2 or more forces BCD decoding in its own units
  assign eff_fmt = (display_unit_select >= DISP_RPM &&
                    input_format_select >= FMT_BCD5) ? 3'h0 : input_format_select;

  drd_decode u_decode (
    .fmt   (eff_fmt),
    .wide  (wide),
    .narrow(narrow),
    .pins  (pins),
    .dec   (dec)
  );

  // A word is taken only while the strobe is high and the word is legal
  assign accept = pins.strobe && !dec.fmt_bad && !dec.digit_bad;

  // Reference unit from display setting and input format
  function automatic drd_unit_type unit_of(input logic [15:0] disp, input logic [2:0] fmt);
    drd_unit_type u;
    u = UNIT_HZ_001;
    if (disp >= DISP_USR)
    begin
      u = UNIT_USER;
    end
    else if (disp >= DISP_RPM)
    begin
      u = UNIT_RPM;
    end
    else if (fmt == FMT_BIN)
    begin
      u = UNIT_BIN;
    end
    else if (fmt != FMT_BCD5)
    begin
      u = drd_unit_type'({1'b0, fmt});
    end
    return u;
  endfunction : unit_of

  // Monitor unit from display setting alone
  function automatic drd_mon_type mon_of(input logic [15:0] disp);
    drd_mon_type m;
    if (disp >= DISP_USR)
    begin
      m = MON_USER;
    end
    else if (disp >= DISP_RPM)
    begin
      m = MON_RPM;
    end
    else if (disp == DISP_RST)
    begin
      m = MON_HZ;
    end
    else
    begin
      m = MON_PCT;
    end
    return m;
  endfunction : mon_of

  // Reference hold: changes only on an accepted word
  always_comb
  begin
    next_ref_mag      = REF_MAG;
    next_ref_reverse  = REF_REVERSE;
    next_ref_full     = REF_FULL_SCALE;
    next_ref_valid    = ref_valid;
    next_ref_update   = 1'b0;
    next_digit_fault  = digit_fault;
    next_format_fault = dec.fmt_bad;
    // Unit belongs to the held word, so it only moves with an accepted word
    next_ref_unit     = drd_unit_type'(REF_UNIT);
    next_mon_unit     = mon_of(display_unit_select);
    if (pins.strobe)
    begin
      next_digit_fault = dec.digit_bad;
    end
    if (accept)
    begin
      next_ref_mag     = dec.mag;
      next_ref_reverse = dec.reverse;
      next_ref_full    = dec.full;
      next_ref_unit    = unit_of(display_unit_select, eff_fmt);
      next_ref_valid   = 1'b1;
      // Pulse only on a real change so a held strobe does not chatter
      next_ref_update  = !ref_valid || dec.mag != REF_MAG ||
                         dec.reverse != REF_REVERSE;
    end
  end

  // Strobe low holds the reference and the digit fault; FORMAT_FAULT and MON_UNIT keep following
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REF_MAG        <= '0;
      REF_REVERSE    <= 1'b0;
      REF_FULL_SCALE <= 1'b0;
      REF_UPDATE     <= 1'b0;
      REF_UNIT       <= UNIT_PCT_1;
      MON_UNIT       <= MON_HZ;
      FORMAT_FAULT   <= 1'b0;
      ref_valid      <= 1'b0;
      digit_fault    <= 1'b0;
    end
    else
    begin
      REF_MAG        <= next_ref_mag;
      REF_REVERSE    <= next_ref_reverse;
      REF_FULL_SCALE <= next_ref_full;
      REF_UPDATE     <= next_ref_update;
      REF_UNIT       <= next_ref_unit;
      MON_UNIT       <= next_mon_unit;
      FORMAT_FAULT   <= next_format_fault;
      ref_valid      <= next_ref_valid;
      digit_fault    <= next_digit_fault;
    end
  end

  // Known register address
  function automatic logic reg_hit(input logic [11:0] a);
    return a == REG_CTRL || a == REG_DISP || a == REG_REF || a == REG_STAT;
  endfunction : reg_hit

  // Read data for one address
  function automatic logic [31:0] reg_read(input logic [11:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      REG_CTRL: r[CTRL_FMT_LSB +: FMT_W] = input_format_select;
      REG_DISP: r[DISP_W-1:0] = display_unit_select;
      REG_REF:  r[15:0] = REF_MAG;
      REG_STAT:
      begin
        r[ST_VALID]      = ref_valid;
        r[ST_FMT]        = FORMAT_FAULT;
        r[ST_DIGIT]      = digit_fault;
        r[ST_REV]        = REF_REVERSE;
        r[ST_FULL]       = REF_FULL_SCALE;
        r[ST_UNIT +: 4]  = REF_UNIT;
        r[ST_MON +: 2]   = MON_UNIT;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : reg_read

  // The transfer ends on the edge that samples PREADY high
  assign apb_done = PSEL && PENABLE && PREADY;

  // One wait state: PREADY rises on the second access cycle
  always_comb
  begin
    next_pready              = PSEL && PENABLE && !PREADY;
    next_prdata              = PRDATA;
    next_pslverr             = 1'b0;
    next_input_format_select = input_format_select;
    next_display_unit_select = display_unit_select;
    if (next_pready)
    begin
      next_prdata  = PWRITE ? 32'h0000_0000 : reg_read(PADDR);
      next_pslverr = !reg_hit(PADDR);
    end
    if (apb_done && PWRITE)
    begin
      unique case (PADDR)
        REG_CTRL: next_input_format_select = PWDATA[CTRL_FMT_LSB +: FMT_W];
        REG_DISP: next_display_unit_select = PWDATA[DISP_W-1:0];
        default:  next_input_format_select = input_format_select;
      endcase
    end
  end

  // Format resets to zero, the BCD one-percent mode
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PREADY              <= 1'b0;
      PRDATA              <= '0;
      PSLVERR             <= 1'b0;
      input_format_select <= FMT_RST;
      display_unit_select <= DISP_RST;
    end
    else
    begin
      PREADY              <= next_pready;
      PRDATA              <= next_prdata;
      PSLVERR             <= next_pslverr;
      input_format_select <= next_input_format_select;
      display_unit_select <= next_display_unit_select;
    end
  end
endmodule : drd_top
`default_nettype wire

// ==== test/drd_top_asserts.sv ====
// Port-level concurrent checks for the digital reference decoder
`timescale 1ns/1ps
`default_nettype none
module drd_top_asserts (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic        REF_STROBE_IN,
  input wire logic [15:0] REF_MAG,
  input wire logic        REF_REVERSE,
  input wire logic        REF_FULL_SCALE,
  input wire logic        REF_UPDATE,
  input wire logic [3:0]  REF_UNIT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // Bus answer timing and shape
  property p_apb_answer; $rose(PENABLE) && PSEL |=> PREADY; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("late bus answer");
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_cause; PREADY |-> $past(PSEL) && $past(PENABLE); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_shape; PSLVERR |-> PREADY && PRDATA == 32'h0000_0000; endproperty
  a_err_shape: assert property (p_err_shape) else $error("error response malformed");

  // Accepted word only moves with its update pulse, and never while unread
  property p_mag_needs_update; $changed(REF_MAG) |-> REF_UPDATE; endproperty
  a_mag_needs_update: assert property (p_mag_needs_update) else $error("silent change");
  property p_hold;
    !REF_STROBE_IN [*8] |=> !REF_UPDATE && $stable(REF_MAG) && $stable(REF_REVERSE);
  endproperty
  a_hold: assert property (p_hold) else $error("reference moved with strobe low");

  // Full scale only for an all-ones binary word
  property p_full;
    REF_FULL_SCALE |-> REF_UNIT == 4'h7 && REF_MAG inside {16'h00FF, 16'h0FFF, 16'hFFFF};
  endproperty
  a_full: assert property (p_full) else $error("full scale on wrong word");
  property p_full_max; REF_UNIT == 4'h7 && REF_MAG == 16'hFFFF |-> REF_FULL_SCALE; endproperty
  a_full_max: assert property (p_full_max) else $error("full scale missed");

  c_update: cover property (REF_UPDATE);
  c_full: cover property (REF_FULL_SCALE);
  c_err: cover property (PSLVERR);
endmodule : drd_top_asserts

bind drd_top drd_top_asserts u_chk (.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .PRDATA, .REF_STROBE_IN, .REF_MAG, .REF_REVERSE, .REF_FULL_SCALE, .REF_UPDATE, .REF_UNIT);
`default_nettype wire

// ==== test/drd_ctrl_model.sv ====
// Behavioural external controller driving the parallel reference lines
`timescale 1ns/1ps
`default_nettype none
module drd_ctrl_model (
  input  wire logic        clk,
  output var  logic [15:0] data,
  output var  logic        sign,
  output var  logic        strobe
);
  // Lines idle with read low
  initial
  begin
    data   = 16'h0000;
    sign   = 1'b0;
    strobe = 1'b0;
  end

  // Word moves only while read is low so the decoder never sees a torn word
  task automatic send(input logic [15:0] d, input logic s, input logic rd);
    @(posedge clk);
    strobe <= 1'b0;
    @(posedge clk);
    data <= d;
    sign <= s;
    @(posedge clk);
    strobe <= rd;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : drd_ctrl_model
`default_nettype wire

// ==== test/test_digital_reference_decoder.sv ====
// Self-checking bench for the digital reference decoder
`timescale 1ns/1ps
`default_nettype none
module test_digital_reference_decoder;
  import drd_pkg::*;
  localparam logic [31:0] DTAB [4] = '{32'h0, 32'h1, 32'h2, 32'h28};
  localparam logic [3:0]  UTAB [4] = '{4'h5, 4'h5, 4'h8, 4'h9};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy, perr, sgn, stb, upd, rev, full, fault;
  logic        wide = 1'b1;
  logic        b8 = 1'b0;
  logic [15:0] dat, mag;
  logic [3:0]  unit;
  logic [1:0]  mon;
  int          fail_count = 0;
  int          comparisons = 0;

  // 20 MHz system clock
  always #25 clk = ~clk;

  drd_ctrl_model ctrl (.clk(clk), .data(dat), .sign(sgn), .strobe(stb));
  drd_top dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .REF_DATA_IN(dat), .REF_SIGN_IN(sgn), .REF_STROBE_IN(stb), .WORD_WIDTH_16_IN(wide),
    .BOARD_8BIT_IN(b8), .REF_MAG(mag), .REF_REVERSE(rev), .REF_FULL_SCALE(full),
    .REF_UPDATE(upd), .REF_UNIT(unit), .MON_UNIT(mon), .FORMAT_FAULT(fault));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One transfer, then an idle cycle so the next setup never collides
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
    else
    begin
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, exp, r);
    check({what, " error"}, {31'h0, err}, {31'h0, e});
  endtask : rd_chk

  // Present a word with read high and compare the accepted value
  task automatic ref_chk(input string what, input logic [15:0] d, input logic s,
                         input logic [15:0] m, input logic r);
    ctrl.send(d, s, 1'b1);
    check(what, {16'h0, m}, {16'h0, mag});
    check({what, " dir"}, {31'h0, r}, {31'h0, rev});
  endtask : ref_chk

  // Bound on the whole run
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk("format reset", REG_CTRL, 32'h0, 1'b0);
    rd_chk("display reset", REG_DISP, 32'h0, 1'b0);
    rd_chk("unmapped", 12'h010, 32'h0, 1'b1);
    wr(REG_CTRL, 32'h7);
    rd_chk("format write", REG_CTRL, 32'h7, 1'b0);
    $display("test registers done");
    ref_chk("bin16", 16'h1234, 1'b1, 16'h1234, 1'b1);
    ref_chk("bin16 max", 16'hFFFF, 1'b0, 16'hFFFF, 1'b0);
    check("full16", 32'h1, {31'h0, full});
    ctrl.send(16'h0001, 1'b1, 1'b0);
    check("strobe low hold", 32'hFFFF, {16'h0, mag});
    wide <= 1'b0;
    ref_chk("bin12", 16'hFABC, 1'b0, 16'h0ABC, 1'b0);
    ref_chk("bin12 max", 16'h0FFF, 1'b0, 16'h0FFF, 1'b0);
    check("full12", 32'h1, {31'h0, full});
    $display("test binary done");
    wide <= 1'b1;
    for (int f = 0; f < 6; f++)
    begin
      wr(REG_CTRL, f);
      ref_chk("bcd4", 16'h1234 + 16'(f), 1'b1, 16'd1234 + 16'(f), 1'b1);
      check("bcd unit", f, {28'h0, unit});
    end
    ref_chk("bcd bad digit", 16'h12A4, 1'b0, 16'd1239, 1'b1);
    wide <= 1'b0;
    ref_chk("bcd3", 16'hF987, 1'b0, 16'd987, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_DISP, DTAB[i]);
      ref_chk("disp bcd", 16'h0321, 1'b0, 16'd321, 1'b0);
      check("ref unit", {28'h0, UTAB[i]}, {28'h0, unit});
      check("mon unit", i, {30'h0, mon});
    end
    wr(REG_DISP, 32'h0);
    $display("test bcd done");
    wr(REG_CTRL, 32'h6);
    wide <= 1'b1;
    ref_chk("fmt6 top", 16'hCCCC, 1'b1, 16'h9C3E, 1'b0);
    check("fmt6 fault", 32'h0, {31'h0, fault});
    ref_chk("fmt6 low", 16'h0003, 1'b0, 16'd6, 1'b0);
    wide <= 1'b0;
    repeat (8) @(posedge clk);
    check("fmt6 narrow fault", 32'h1, {31'h0, fault});
    wide <= 1'b1;
    b8 <= 1'b1;
    repeat (8) @(posedge clk);
    check("fmt6 byte board fault", 32'h1, {31'h0, fault});
    $display("test five digit done");
    wr(REG_CTRL, 32'h7);
    ref_chk("bin8", 16'hAB5A, 1'b1, 16'h005A, 1'b1);
    ref_chk("bin8 max", 16'h12FF, 1'b0, 16'h00FF, 1'b0);
    check("full8", 32'h1, {31'h0, full});
    wr(REG_CTRL, 32'h0);
    ref_chk("bcd8", 16'h00F9, 1'b0, 16'd159, 1'b0);
    ref_chk("bcd8 bad low", 16'h001A, 1'b1, 16'd159, 1'b0);
    rd_chk("ref reg", REG_REF, 32'h0000_009F, 1'b0);
    rd_chk("status", REG_STAT, 32'h0000_0005, 1'b0);
    $display("test byte board done");
    stop_test();
  end
endmodule : test_digital_reference_decoder
`default_nettype wire
